// [hdl/ssp_pkg.sv]
// Shared constants and types of the synchronous serial port.
package ssp_pkg;

	localparam int unsigned SSP_MODE_W = 2;

	// Port operating modes.
	localparam logic [1:0] SSP_MODE_OFF        = 2'h0;
	localparam logic [1:0] SSP_MODE_SPI_SLAVE  = 2'h1;
	localparam logic [1:0] SSP_MODE_I2C_SLAVE  = 2'h2;
	localparam logic [1:0] SSP_MODE_I2C_MASTER = 2'h3;

	// Bit counter landmarks of a byte frame.
	localparam logic [3:0] SSP_BIT_FIRST = 4'h0;
	localparam logic [3:0] SSP_BIT_LAST  = 4'h7;
	localparam logic [3:0] SSP_BIT_ACK   = 4'h8;
	localparam logic [3:0] SSP_BIT_DONE  = 4'h9;

	// Quarter phases of one master clock period.
	localparam logic [1:0] SSP_QPH_0 = 2'h0;
	localparam logic [1:0] SSP_QPH_1 = 2'h1;
	localparam logic [1:0] SSP_QPH_2 = 2'h2;
	localparam logic [1:0] SSP_QPH_3 = 2'h3;

	// Master bus timing: a quarter of the serial clock period.
	localparam int unsigned SSP_CLK_MHZ = 200;
	localparam int unsigned SSP_QTR_NS  = 2500;
	localparam int unsigned SSP_QTR_CYC = (SSP_QTR_NS * SSP_CLK_MHZ + 999) / 1000;
	localparam int unsigned SSP_QCNT_W  = 16;

	// Reset values.
	localparam logic [7:0] SSP_BYTE_RST = 8'h00;
	localparam logic [6:0] SSP_ADDR_RST = 7'h00;

	typedef enum logic [2:0] {
		SSP_M_IDLE,
		SSP_M_START,
		SSP_M_HOLD,
		SSP_M_TX,
		SSP_M_STOP,
		SSP_M_RESTART
	} ssp_mst_t;

endpackage

// [hdl/ssp_sync.sv]
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ssp_sync_t;

	ssp_sync_t st_q;
	ssp_sync_t st_d;

	if (W < 1) begin : g_chk
		$error("ssp_sync needs at least one bit");
	end

	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;

endmodule
`default_nettype wire

// [hdl/ssp_port.sv]
// Synchronous serial port: SPI slave, I2C slave receive and I2C master transmit.
`timescale 1ns/1ps
`default_nettype none
module ssp_port import ssp_pkg::*; #(
	parameter int unsigned QTR_CYC = SSP_QTR_CYC
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	input  wire logic [SSP_MODE_W-1:0] MODE,
	input  wire logic [6:0]            SLAVE_ADDR,
	input  wire logic                  BUF_WR,
	input  wire logic [7:0]            BUF_WDATA,
	input  wire logic                  BUF_RD,
	output logic      [7:0]            BUF_RDATA,
	input  wire logic                  CKP_WR,
	input  wire logic                  CKP_WDATA,
	output logic                       CLOCK_RELEASE_POLARITY,
	input  wire logic                  START_OR_STRETCH_ENABLE,
	input  wire logic                  STOP_GENERATE,
	input  wire logic                  RESTART_GENERATE,
	input  wire logic                  ACK_VALUE_SELECT,
	input  wire logic                  START_IRQ_EN,
	input  wire logic                  STOP_IRQ_EN,
	input  wire logic                  IRQ_CLEAR,
	input  wire logic                  WRITE_COLLISION_FLAG_CLEAR,
	input  wire logic                  WAKE_EN,
	output logic                       PORT_IRQ_FLAG,
	output logic                       WAKE,
	output logic                       BUFFER_FULL_FLAG,
	output logic                       WRITE_COLLISION_FLAG,
	output logic                       ACK_RECEIVED_FLAG,
	output logic                       ACK_TIMING_FLAG,
	output logic                       START_SEEN,
	output logic                       STOP_SEEN,
	input  wire logic                  SCK_IN,
	input  wire logic                  SDI,
	output logic                       SDO,
	input  wire logic                  SCL_I,
	output logic                       SCL_O,
	output logic                       SCL_OE,
	input  wire logic                  SDA_I,
	output logic                       SDA_O,
	output logic                       SDA_OE
);

	////////////////////////////////////////////////////////////////////////////////

	localparam logic [SSP_QCNT_W-1:0] QTR_LAST = SSP_QCNT_W'(QTR_CYC - 1);

	if (QTR_CYC < 2 || QTR_CYC > 65535) begin : g_chk
		$error("ssp_port: QTR_CYC must lie between 2 and 65535");
	end

	typedef struct packed {
		logic                  sck_p;
		logic                  scl_p;
		logic                  sda_p;
		logic                  sen_p;
		logic [7:0]            sr;
		logic [7:0]            dbuf;
		logic [3:0]            bcnt;
		logic                  sdo;
		logic                  clock_release_polarity;
		logic                  irq;
		logic                  bf;
		logic                  write_collision_flag;
		logic                  ack_received_flag;
		logic                  ack_timing_flag;
		logic                  start_seen;
		logic                  stop_seen;
		logic                  sl_act;
		logic                  sl_data;
		logic                  ackdrv;
		ssp_mst_t              mst;
		logic [1:0]            qph;
		logic [SSP_QCNT_W-1:0] qcnt;
		logic [3:0]            mbit;
		logic                  m_scl;
		logic                  m_sda;
	} ssp_state_t;

	ssp_state_t q;
	ssp_state_t n;
	logic [3:0] pins_s;
	logic       sck_s;
	logic       sdi_s;
	logic       scl_s;
	logic       sda_s;
	logic       spi_lead;
	logic       spi_trail;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       tick;
	logic       irq_set;
	logic       bf_set;
	logic       addr_hit;

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
		shift_in = {v[6:0], b};
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	ssp_sync #(
		.W (4)
	) u_sync (
		.clk (CORE_CLK),
		.rst (RST),
		.ce  (CE),
		.d   ({SCK_IN, SDI, SCL_I, SDA_I}),
		.q   (pins_s)
	);

	assign {sck_s, sdi_s, scl_s, sda_s} = pins_s;

	// The leading edge leaves the idle level chosen by the polarity bit.
	assign spi_lead  = (q.sck_p == q.clock_release_polarity) && (sck_s != q.clock_release_polarity);
	assign spi_trail = (q.sck_p != q.clock_release_polarity) && (sck_s == q.clock_release_polarity);
	assign scl_rise  = scl_s && !q.scl_p;
	assign scl_fall  = !scl_s && q.scl_p;
	assign start_ev  = scl_s && q.scl_p && q.sda_p && !sda_s;
	assign stop_ev   = scl_s && q.scl_p && !q.sda_p && sda_s;
	assign tick      = (q.qcnt == QTR_LAST);
	assign addr_hit  = (q.sr[7:1] == SLAVE_ADDR) && !q.sr[0];

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		n       = q;
		irq_set = 1'b0;
		bf_set  = 1'b0;
		n.sck_p = sck_s;
		n.scl_p = scl_s;
		n.sda_p = sda_s;
		n.sen_p = START_OR_STRETCH_ENABLE;
		if (IRQ_CLEAR) begin
			n.irq = 1'b0;
		end
		if (WRITE_COLLISION_FLAG_CLEAR) begin
			n.write_collision_flag = 1'b0;
		end
		if (BUF_RD) begin
			n.bf = 1'b0;
		end
		if (CKP_WR) begin
			n.clock_release_polarity = CKP_WDATA;
		end
		unique case (MODE)
			SSP_MODE_SPI_SLAVE: begin
				if (BUF_WR) begin
					if (q.bcnt != SSP_BIT_FIRST) begin
						n.write_collision_flag = 1'b1;
					end else begin
						n.sr  = BUF_WDATA;
						n.sdo = BUF_WDATA[7];
					end
				end
				// Received bits stay in the shifter, so an unreloaded byte is echoed.
				if (spi_lead) begin
					n.sr = shift_in(n.sr, sdi_s);
					if (q.bcnt == SSP_BIT_LAST) begin
						n.dbuf  = n.sr;
						n.bcnt  = SSP_BIT_FIRST;
						bf_set  = 1'b1;
						irq_set = 1'b1;
					end else begin
						n.bcnt = q.bcnt + 4'h1;
					end
				end else if (spi_trail) begin
					n.sdo = q.sr[7];
				end
			end
			SSP_MODE_I2C_SLAVE: begin
				if (start_ev) begin
					n.start_seen = 1'b1;
					n.stop_seen  = 1'b0;
					irq_set      = START_IRQ_EN;
					n.sl_act     = 1'b1;
					n.sl_data    = 1'b0;
					n.bcnt       = SSP_BIT_FIRST;
					n.ackdrv     = 1'b0;
				end else if (stop_ev) begin
					n.stop_seen  = 1'b1;
					n.start_seen = 1'b0;
					irq_set      = STOP_IRQ_EN;
					n.sl_act     = 1'b0;
					n.ackdrv     = 1'b0;
				end else if (q.sl_act && scl_rise && q.bcnt < SSP_BIT_ACK) begin
					n.sr   = shift_in(q.sr, sda_s);
					n.bcnt = q.bcnt + 4'h1;
				end else if (q.sl_act && scl_fall && q.bcnt == SSP_BIT_ACK) begin
					if (q.sl_data || addr_hit) begin
						n.dbuf   = q.sr;
						bf_set   = 1'b1;
						irq_set  = 1'b1;
						n.clock_release_polarity    = 1'b0;
						n.ack_timing_flag = 1'b1;
						n.ackdrv = 1'b1;
						n.bcnt   = SSP_BIT_DONE;
					end else begin
						n.sl_act = 1'b0;
					end
				end else if (q.sl_act && scl_fall && q.bcnt == SSP_BIT_DONE) begin
					n.ack_timing_flag  = 1'b0;
					n.ackdrv  = 1'b0;
					n.bcnt    = SSP_BIT_FIRST;
					n.sl_data = 1'b1;
					if (!ACK_VALUE_SELECT) begin
						irq_set = 1'b1;
						if (START_OR_STRETCH_ENABLE) begin
							n.clock_release_polarity = 1'b0;
						end
					end else begin
						n.sl_act = 1'b0;
					end
				end
			end
			SSP_MODE_I2C_MASTER: begin
				if (BUF_WR && q.mst != SSP_M_HOLD) begin
					n.write_collision_flag = 1'b1;
				end
				n.qcnt = tick ? '0 : q.qcnt + SSP_QCNT_W'(1);
				unique case (q.mst)
					SSP_M_IDLE: begin
						n.qcnt  = '0;
						n.m_scl = 1'b0;
						n.m_sda = 1'b0;
						if (START_OR_STRETCH_ENABLE && !q.sen_p) begin
							n.mst = SSP_M_START;
							n.qph = SSP_QPH_0;
						end
					end
					SSP_M_HOLD: begin
						n.qcnt  = '0;
						n.qph   = SSP_QPH_0;
						n.m_scl = 1'b1;
						n.m_sda = 1'b0;
						if (BUF_WR) begin
							n.mst   = SSP_M_TX;
							n.sr    = BUF_WDATA;
							n.mbit  = SSP_BIT_FIRST;
							n.m_sda = !BUF_WDATA[7];
							bf_set  = 1'b1;
						end else if (STOP_GENERATE) begin
							n.mst = SSP_M_STOP;
						end else if (RESTART_GENERATE) begin
							n.mst = SSP_M_RESTART;
						end
					end
					SSP_M_START: begin
						if (tick) begin
							n.qph = q.qph + 2'h1;
							if (q.qph == SSP_QPH_1) begin
								n.m_sda = 1'b1;
							end
							// Two quarters of data low under a high clock give the hold time.
							if (q.qph == SSP_QPH_3) begin
								n.m_scl = 1'b1;
								irq_set = 1'b1;
								n.mst   = SSP_M_HOLD;
							end
						end
					end
					SSP_M_RESTART: begin
						if (tick) begin
							n.qph = q.qph + 2'h1;
							unique case (q.qph)
								SSP_QPH_0: n.m_sda = 1'b0;
								SSP_QPH_1: n.m_scl = 1'b0;
								SSP_QPH_2: n.m_sda = 1'b1;
								SSP_QPH_3: begin
									n.m_scl = 1'b1;
									irq_set = 1'b1;
									n.mst   = SSP_M_HOLD;
								end
							endcase
						end
					end
					SSP_M_STOP: begin
						if (tick) begin
							n.qph = q.qph + 2'h1;
							unique case (q.qph)
								SSP_QPH_0: n.m_sda = 1'b1;
								SSP_QPH_1: n.m_scl = 1'b0;
								SSP_QPH_2: n.m_sda = 1'b0;
								SSP_QPH_3: begin
									irq_set = 1'b1;
									n.mst   = SSP_M_IDLE;
								end
							endcase
						end
					end
					SSP_M_TX: begin
						if (tick) begin
							n.qph = q.qph + 2'h1;
							unique case (q.qph)
								// Data moves a quarter after the clock falls, never with it.
								SSP_QPH_0: n.m_sda = (q.mbit == SSP_BIT_ACK) ? 1'b0 : !q.sr[7];
								SSP_QPH_1: n.m_scl = 1'b0;
								SSP_QPH_2: begin
									if (q.mbit == SSP_BIT_ACK) begin
										n.ack_received_flag = sda_s;
									end
								end
								SSP_QPH_3: begin
									n.m_scl = 1'b1;
									if (q.mbit == SSP_BIT_ACK) begin
										irq_set = 1'b1;
										n.mst   = SSP_M_HOLD;
									end else begin
										n.mbit = q.mbit + 4'h1;
										n.sr   = {q.sr[6:0], 1'b0};
										if (q.mbit == SSP_BIT_LAST) begin
											n.bf = 1'b0;
										end
									end
								end
							endcase
						end
					end
					default: begin
						n.mst = SSP_M_IDLE;
					end
				endcase
			end
			SSP_MODE_OFF: begin
				n.bcnt   = SSP_BIT_FIRST;
				n.sl_act = 1'b0;
				n.ackdrv = 1'b0;
				n.ack_timing_flag = 1'b0;
				n.mst    = SSP_M_IDLE;
				n.qcnt   = '0;
				n.m_scl  = 1'b0;
				n.m_sda  = 1'b0;
			end
		endcase
		// Hardware events win over a clear in the same cycle.
		if (irq_set) begin
			n.irq = 1'b1;
		end
		if (bf_set) begin
			n.bf = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			q      <= '0;
			q.mst  <= SSP_M_IDLE;
			q.sr   <= SSP_BYTE_RST;
			q.dbuf <= SSP_BYTE_RST;
		end else if (CE) begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign BUF_RDATA              = q.dbuf;
	assign CLOCK_RELEASE_POLARITY = q.clock_release_polarity;
	assign PORT_IRQ_FLAG          = q.irq;
	assign WAKE                   = q.irq && WAKE_EN;
	assign BUFFER_FULL_FLAG       = q.bf;
	assign WRITE_COLLISION_FLAG   = q.write_collision_flag;
	assign ACK_RECEIVED_FLAG      = q.ack_received_flag;
	assign ACK_TIMING_FLAG        = q.ack_timing_flag;
	assign START_SEEN             = q.start_seen;
	assign STOP_SEEN              = q.stop_seen;
	assign SDO                    = q.sdo;
	assign SCL_O                  = 1'b0;
	assign SDA_O                  = 1'b0;
	assign SCL_OE = (MODE == SSP_MODE_I2C_MASTER) ? q.m_scl :
		((MODE == SSP_MODE_I2C_SLAVE) && q.sl_act && !q.clock_release_polarity);
	assign SDA_OE = (MODE == SSP_MODE_I2C_MASTER) ? q.m_sda :
		((MODE == SSP_MODE_I2C_SLAVE) && q.ackdrv && !ACK_VALUE_SELECT);

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_spi_byte_done: assert property (
		CE && MODE == SSP_MODE_SPI_SLAVE && spi_lead && q.bcnt == SSP_BIT_LAST
		|=> q.irq && q.bf && q.bcnt == SSP_BIT_FIRST)
		else $error("SPI byte end did not flag the byte");

	a_spi_lead_count: assert property (
		CE && MODE == SSP_MODE_SPI_SLAVE && spi_lead && q.bcnt < SSP_BIT_LAST
		|=> q.bcnt == $past(q.bcnt) + 4'h1)
		else $error("SPI leading edge did not advance the bit count");

	a_spi_echo: assert property (
		CE && MODE == SSP_MODE_SPI_SLAVE && spi_lead && q.bcnt == SSP_BIT_LAST && !BUF_WR
		|=> q.sr == q.dbuf)
		else $error("SPI shifter lost the received byte");

	a_start_flag: assert property (
		CE && MODE == SSP_MODE_I2C_SLAVE && start_ev
		|=> q.start_seen && (q.irq || !$past(START_IRQ_EN)))
		else $error("Start did not set the start flag");

	a_eighth_stretch: assert property (
		CE && MODE == SSP_MODE_I2C_SLAVE && !start_ev && !stop_ev && q.sl_act && scl_fall
		&& q.bcnt == SSP_BIT_ACK && q.sl_data
		|=> q.irq && !q.clock_release_polarity && q.ack_timing_flag && SCL_OE)
		else $error("Eighth falling edge did not stretch and flag");

	a_ninth_irq: assert property (
		CE && MODE == SSP_MODE_I2C_SLAVE && !start_ev && !stop_ev && q.sl_act && scl_fall
		&& q.bcnt == SSP_BIT_DONE && !ACK_VALUE_SELECT
		|=> q.irq && !q.ack_timing_flag && q.sl_data)
		else $error("Ninth falling edge after ack did not flag");

	a_ack_drive: assert property (
		MODE == SSP_MODE_I2C_SLAVE && q.ackdrv |-> SDA_OE == !ACK_VALUE_SELECT)
		else $error("Slave drives the wrong ack level");

	a_master_full: assert property (
		CE && MODE == SSP_MODE_I2C_MASTER && q.mst == SSP_M_HOLD && BUF_WR
		|=> q.bf && q.mst == SSP_M_TX)
		else $error("Master write did not start a byte");

	a_write_collision_flag_discard: assert property (
		CE && MODE == SSP_MODE_I2C_MASTER && q.mst == SSP_M_TX && BUF_WR
		|=> q.write_collision_flag && q.sr == $past(q.sr) || q.write_collision_flag && $past(tick))
		else $error("Colliding write was not flagged");

	a_hold_lines: assert property (
		MODE == SSP_MODE_I2C_MASTER && q.mst == SSP_M_HOLD && $past(q.mst) == SSP_M_HOLD
		&& $past(MODE) == SSP_MODE_I2C_MASTER |-> SCL_OE && !SDA_OE)
		else $error("Master hold left the lines wrong");

	c_spi_byte:   cover property (CE && MODE == SSP_MODE_SPI_SLAVE && spi_lead
		&& q.bcnt == SSP_BIT_LAST);
	c_slave_data: cover property (CE && MODE == SSP_MODE_I2C_SLAVE && scl_fall
		&& q.bcnt == SSP_BIT_DONE && q.sl_data);
	c_master_ack: cover property (CE && q.mst == SSP_M_TX && tick && q.qph == SSP_QPH_3
		&& q.mbit == SSP_BIT_ACK);
	c_master_stop: cover property (CE && q.mst == SSP_M_STOP && tick && q.qph == SSP_QPH_3);

endmodule
`default_nettype wire

// [verification/ssp_far.sv]
// Far-side model: SPI master, I2C master and acknowledging remote I2C slave.
`timescale 1ns/1ps
`default_nettype none
module ssp_far (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sdo,
	input  wire logic ack_en,
	output logic      sck,
	output logic      sdi,
	output logic      scl_pull,
	output logic      sda_pull
);
	logic       m_sda;
	logic       r_sda;
	logic [7:0] rcv;
	int         bitn;
	assign sda_pull = m_sda | r_sda;
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		scl_pull = 1'b0;
		m_sda = 1'b0;
		r_sda = 1'b0;
		bitn = 9;
		rcv = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Remote slave: a Start restarts the count, the ack goes out after the eighth fall.
	always @(negedge sda) if (scl) bitn = -1;
	always @(posedge scl) if (bitn >= 0 && bitn < 8) rcv = {rcv[6:0], sda};
	always @(negedge scl) begin
		bitn = bitn + 1;
		r_sda = ack_en && bitn == 8;
		if (bitn == 9) bitn = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic spi_idle(input logic c);
		sck <= c;
		@(posedge clk);
	endtask
	task automatic spi_xfer(input logic cpol, input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi <= tx[i];
			repeat (4) @(posedge clk);
			sck <= ~cpol;
			rx[i] = sdo;
			repeat (4) @(posedge clk);
			sck <= cpol;
		end
		sdi <= ~tx[0];
	endtask
	task automatic i2c_start();
		m_sda <= 1'b1;
		repeat (8) @(posedge clk);
		scl_pull <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic i2c_bit(input logic b, output logic seen);
		m_sda <= ~b;
		repeat (8) @(posedge clk);
		scl_pull <= 1'b0;
		for (int i = 0; i < 400 && !scl; i++) @(posedge clk);
		repeat (8) @(posedge clk);
		seen = sda;
		scl_pull <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic i2c_stop();
		m_sda <= 1'b1;
		repeat (8) @(posedge clk);
		scl_pull <= 1'b0;
		repeat (8) @(posedge clk);
		m_sda <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// [verification/test_sync_serial_port_i2c_spi.sv]
// Self-checking testbench of the synchronous serial port.
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_port_i2c_spi import ssp_pkg::*;;
	localparam logic [6:0] P_WR = 7'h01, P_RD = 7'h02, P_IRQ = 7'h04, P_WRITE_COLLISION_FLAG = 7'h08;
	localparam logic [6:0] P_CKP = 7'h10, P_STOP = 7'h20, P_RSTRT = 7'h40;
	logic       CORE_CLK = 1'b0;
	logic       RST = 1'b1;
	logic [1:0] MODE = SSP_MODE_OFF;
	logic [6:0] pl = 7'h00;
	logic [7:0] BUF_WDATA = 8'h00;
	logic       CKP_WDATA = 1'b0;
	logic       START_OR_STRETCH_ENABLE = 1'b0;
	logic       ACK_VALUE_SELECT = 1'b0;
	logic       WAKE_EN = 1'b0;
	logic       ack_en = 1'b0;
	logic       CE = 1'b1;
	logic       START_IRQ_EN = 1'b1;
	logic       STOP_IRQ_EN = 1'b0;
	logic [7:0] BUF_RDATA, rx;
	logic       CLOCK_RELEASE_POLARITY, PORT_IRQ_FLAG, WAKE, BUFFER_FULL_FLAG;
	logic       WRITE_COLLISION_FLAG, ACK_RECEIVED_FLAG, ACK_TIMING_FLAG, START_SEEN;
	logic       STOP_SEEN, SDO, SCL_OE, SDA_OE, sck, sdi, p_scl, p_sda, b;
	wire        scl_w;
	wire        sda_w;
	int         failures = 0;
	int         tests_run = 0;
	int         cyc = 0;
	// Open-drain lines with pull-ups.
	assign scl_w = ~(SCL_OE | p_scl);
	assign sda_w = ~(SDA_OE | p_sda);
	always #2.5 CORE_CLK = ~CORE_CLK;
	ssp_port #(.QTR_CYC(4)) ssp_port_i (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE),
		.MODE(MODE), .SLAVE_ADDR(7'h2a), .BUF_WR(pl[0]), .BUF_WDATA(BUF_WDATA),
		.BUF_RD(pl[1]), .BUF_RDATA(BUF_RDATA), .CKP_WR(pl[4]), .CKP_WDATA(CKP_WDATA),
		.CLOCK_RELEASE_POLARITY(CLOCK_RELEASE_POLARITY),
		.START_OR_STRETCH_ENABLE(START_OR_STRETCH_ENABLE), .STOP_GENERATE(pl[5]),
		.RESTART_GENERATE(pl[6]), .ACK_VALUE_SELECT(ACK_VALUE_SELECT),
		.START_IRQ_EN(START_IRQ_EN), .STOP_IRQ_EN(STOP_IRQ_EN), .IRQ_CLEAR(pl[2]),
		.WRITE_COLLISION_FLAG_CLEAR(pl[3]),
		.WAKE_EN(WAKE_EN), .PORT_IRQ_FLAG(PORT_IRQ_FLAG), .WAKE(WAKE),
		.BUFFER_FULL_FLAG(BUFFER_FULL_FLAG), .WRITE_COLLISION_FLAG(WRITE_COLLISION_FLAG),
		.ACK_RECEIVED_FLAG(ACK_RECEIVED_FLAG), .ACK_TIMING_FLAG(ACK_TIMING_FLAG),
		.START_SEEN(START_SEEN), .STOP_SEEN(STOP_SEEN), .SCK_IN(sck), .SDI(sdi), .SDO(SDO),
		.SCL_I(scl_w), .SCL_O(), .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(), .SDA_OE(SDA_OE));
	ssp_far ssp_far_i (.clk(CORE_CLK), .scl(scl_w), .sda(sda_w), .sdo(SDO), .ack_en(ack_en),
		.sck(sck), .sdi(sdi), .scl_pull(p_scl), .sda_pull(p_sda));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask
	// Pulses end at the taking edge and the task returns a cycle later, so flags are settled on return.
	task automatic pulse(input logic [6:0] m);
		pl <= m;
		tick(1);
		pl <= 7'h00;
		tick(1);
	endtask
	task automatic wait_irq(input int n);
		for (int i = 0; i < n && PORT_IRQ_FLAG !== 1'b1; i++) tick(1);
		check("irq wait", PORT_IRQ_FLAG, 8'h01);
	endtask
	task automatic send_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) ssp_far_i.i2c_bit(d[i], b);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_spi();
		MODE <= SSP_MODE_SPI_SLAVE;
		WAKE_EN <= 1'b1;
		BUF_WDATA <= 8'ha5;
		pulse(P_WR);
		ssp_far_i.spi_xfer(1'b0, 8'h3c, rx);
		tick(4);
		check("spi rx", rx, 8'ha5);
		check("spi irq", PORT_IRQ_FLAG, 8'h01);
		check("spi wake", WAKE, 8'h01);
		check("spi bf", BUFFER_FULL_FLAG, 8'h01);
		check("spi rdata", BUF_RDATA, 8'h3c);
		pulse(P_RD | P_IRQ);
		check("spi bf read", BUFFER_FULL_FLAG, 8'h00);
		ssp_far_i.spi_xfer(1'b0, 8'h00, rx);
		tick(4);
		check("daisy echo", rx, 8'h3c);
		MODE <= SSP_MODE_OFF;
		CKP_WDATA <= 1'b1;
		pulse(P_CKP);
		ssp_far_i.spi_idle(1'b1);
		MODE <= SSP_MODE_SPI_SLAVE;
		BUF_WDATA <= 8'hc3;
		tick(2);
		pulse(P_WR);
		ssp_far_i.spi_xfer(1'b1, 8'h96, rx);
		tick(4);
		check("spi idle high rx", rx, 8'hc3);
		check("spi idle high rdata", BUF_RDATA, 8'h96);
		// A clear while the clock enable is low must not reach the flag.
		CE <= 1'b0;
		pulse(P_IRQ);
		check("frozen irq", PORT_IRQ_FLAG, 8'h01);
		CE <= 1'b1;
		WAKE_EN <= 1'b0;
		tick(2);
		check("wake masked", WAKE, 8'h00);
		MODE <= SSP_MODE_OFF;
		ssp_far_i.spi_idle(1'b0);
		$display("test spi done");
	endtask
	task automatic test_i2c_slave();
		MODE <= SSP_MODE_I2C_SLAVE;
		START_OR_STRETCH_ENABLE <= 1'b1;
		pulse(P_IRQ);
		ssp_far_i.i2c_start();
		check("start seen", START_SEEN, 8'h01);
		check("start irq", PORT_IRQ_FLAG, 8'h01);
		pulse(P_IRQ);
		send_byte(8'h54);
		check("addr irq", PORT_IRQ_FLAG, 8'h01);
		check("addr stretch", SCL_OE, 8'h01);
		check("addr ckp", CLOCK_RELEASE_POLARITY, 8'h00);
		check("addr ack timing", ACK_TIMING_FLAG, 8'h01);
		check("addr rdata", BUF_RDATA, 8'h54);
		pulse(P_RD | P_IRQ);
		check("addr bf read", BUFFER_FULL_FLAG, 8'h00);
		check("ack driven", SDA_OE, 8'h01);
		pulse(P_CKP);
		check("released", SCL_OE, 8'h00);
		ssp_far_i.i2c_bit(1'b1, b);
		check("ack level", b, 8'h00);
		check("ninth irq", PORT_IRQ_FLAG, 8'h01);
		check("after ack timing", ACK_TIMING_FLAG, 8'h00);
		check("stretch after ack", SCL_OE, 8'h01);
		ACK_VALUE_SELECT <= 1'b1;
		pulse(P_IRQ | P_CKP);
		send_byte(8'h81);
		check("data irq", PORT_IRQ_FLAG, 8'h01);
		check("data rdata", BUF_RDATA, 8'h81);
		check("data bf", BUFFER_FULL_FLAG, 8'h01);
		check("nack level", SDA_OE, 8'h00);
		pulse(P_IRQ | P_CKP);
		ssp_far_i.i2c_bit(1'b1, b);
		check("nack seen", b, 8'h01);
		check("no irq after nack", PORT_IRQ_FLAG, 8'h00);
		ssp_far_i.i2c_stop();
		check("stop seen", STOP_SEEN, 8'h01);
		check("stop irq off", PORT_IRQ_FLAG, 8'h00);
		START_IRQ_EN <= 1'b0;
		STOP_IRQ_EN <= 1'b1;
		ssp_far_i.i2c_start();
		check("start seen again", START_SEEN, 8'h01);
		check("start irq masked", PORT_IRQ_FLAG, 8'h00);
		ssp_far_i.i2c_stop();
		check("stop seen again", STOP_SEEN, 8'h01);
		check("stop irq on", PORT_IRQ_FLAG, 8'h01);
		$display("test i2c slave done");
	endtask
	task automatic test_i2c_master();
		MODE <= SSP_MODE_OFF;
		START_OR_STRETCH_ENABLE <= 1'b0;
		ack_en <= 1'b1;
		tick(2);
		MODE <= SSP_MODE_I2C_MASTER;
		pulse(P_IRQ);
		START_OR_STRETCH_ENABLE <= 1'b1;
		tick(2);
		check("start pending", PORT_IRQ_FLAG, 8'h00);
		wait_irq(40);
		// Data is let go one cycle after the clock is held low.
		tick(1);
		check("hold scl", SCL_OE, 8'h01);
		check("hold sda", SDA_OE, 8'h00);
		BUF_WDATA <= 8'ha4;
		pulse(P_IRQ | P_WR);
		check("bf set", BUFFER_FULL_FLAG, 8'h01);
		BUF_WDATA <= 8'h77;
		pulse(P_WR);
		check("collision", WRITE_COLLISION_FLAG, 8'h01);
		wait_irq(200);
		check("ack stat", ACK_RECEIVED_FLAG, 8'h00);
		check("bf clear", BUFFER_FULL_FLAG, 8'h00);
		check("sent byte", ssp_far_i.rcv, 8'ha4);
		pulse(P_WRITE_COLLISION_FLAG | P_IRQ);
		check("collision cleared", WRITE_COLLISION_FLAG, 8'h00);
		ack_en <= 1'b0;
		BUF_WDATA <= 8'h5b;
		pulse(P_WR);
		wait_irq(200);
		check("nack stat", ACK_RECEIVED_FLAG, 8'h01);
		check("sent byte 2", ssp_far_i.rcv, 8'h5b);
		pulse(P_IRQ | P_RSTRT);
		check("restart pending", PORT_IRQ_FLAG, 8'h00);
		wait_irq(40);
		pulse(P_IRQ | P_STOP);
		check("stop pending", PORT_IRQ_FLAG, 8'h00);
		wait_irq(40);
		tick(2);
		check("idle scl", SCL_OE, 8'h00);
		check("idle sda", SDA_OE, 8'h00);
		$display("test i2c master done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		tick(8);
		RST <= 1'b0;
		tick(1);
		check("reset irq", PORT_IRQ_FLAG, 8'h00);
		check("reset bf", BUFFER_FULL_FLAG, 8'h00);
		check("reset oe", {SCL_OE, SDA_OE, SDO, CLOCK_RELEASE_POLARITY}, 8'h00);
		$display("test reset done");
		test_spi();
		test_i2c_slave();
		test_i2c_master();
		give_verdict();
	end
endmodule
`default_nettype wire
